//--- pirq_regs.svh
/*
  Register map, field positions, reset values and codes for the primary
  interrupt flag and enable registers.
  Assumes it is included by its bare name; holds definitions only.
*/
`ifndef PIRQ_REGS_SVH
`define PIRQ_REGS_SVH

`define PIRQ_ADDR_W 2
`define PIRQ_ADDR_GRP1 2'h1
`define PIRQ_ADDR_GRP2 2'h2
`define PIRQ_ADDR_GRP3 2'h3
`define PIRQ_ADDR_CTRL 2'h0
`define PIRQ_RST_BYTE 8'h00
`define PIRQ_RST_EDGE 2'h0
`define PIRQ_RST_BIT 1'b0

`define PIRQ_G1_CONV_F 7
`define PIRQ_G1_MF1_F 6
`define PIRQ_G1_MF0_F 5
`define PIRQ_G1_CMP1_F 4
`define PIRQ_G1_CONV_E 3
`define PIRQ_G1_MF1_E 2
`define PIRQ_G1_MF0_E 1
`define PIRQ_G1_CMP1_E 0
`define PIRQ_G2_MF3_F 7
`define PIRQ_G2_TB1_F 6
`define PIRQ_G2_TB0_F 5
`define PIRQ_G2_MF2_F 4
`define PIRQ_G2_MF3_E 3
`define PIRQ_G2_TB1_E 2
`define PIRQ_G2_TB0_E 1
`define PIRQ_G2_MF2_E 0
`define PIRQ_G3_MF5_F 7
`define PIRQ_G3_MF4_F 6
`define PIRQ_G3_PIN3_F 5
`define PIRQ_G3_PIN2_F 4
`define PIRQ_G3_MF5_E 3
`define PIRQ_G3_MF4_E 2
`define PIRQ_G3_PIN3_E 1
`define PIRQ_G3_PIN2_E 0

`define PIRQ_CTRL_GIE 0
`define PIRQ_CTRL_P2S_LO 2
`define PIRQ_CTRL_P3S_LO 4

`define PIRQ_EDGE_OFF 2'h0
`define PIRQ_EDGE_RISE 2'h1
`define PIRQ_EDGE_FALL 2'h2
`define PIRQ_EDGE_BOTH 2'h3

`endif

//--- pirq_pkg.sv
/*
  Types for the primary interrupt flag and enable registers.
  Assumes pirq_regs.svh supplies the numeric constants.
*/
package pirq_pkg;
  typedef struct packed {
    logic [7:0] grp1;
    logic [7:0] grp2;
    logic [7:0] grp3;
    logic global_irq_enable;
    logic [1:0] ext_pin2_edge_select;
    logic [1:0] ext_pin3_edge_select;
    logic pin2_prev;
    logic pin3_prev;
    logic [11:0] irq_req;
    logic [7:0] rdata;
  } pirq_state_type;

  typedef struct packed {
    logic converter;
    logic comparator1;
    logic timebase0;
    logic timebase1;
    logic [5:0] multifunc;
  } pirq_src_type;
endpackage : pirq_pkg

//--- pirq_top.sv
/*
  Primary interrupt request flags and enables for converter, comparator 1,
  time bases 0/1, external pins 2/3 and multi-function groups 0..5.
  Assumes one clock, synchronous sources and pins, a plain register port
  with read data one cycle after the read strobe, and a core that takes
  the per-source request levels.
*/
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pirq_regs.svh"

module pirq_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [`PIRQ_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire pirq_pkg::pirq_src_type src_event,
  input wire logic ext_pin2,
  input wire logic ext_pin3,
  output logic [11:0] irq_req
);

  pirq_pkg::pirq_state_type st_r;
  pirq_pkg::pirq_state_type st_nxt;

  // Edge detection shared by both pins
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    case (sel)
      `PIRQ_EDGE_RISE: edge_hit = rise;
      `PIRQ_EDGE_FALL: edge_hit = fall;
      `PIRQ_EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  logic wr_g1;
  logic wr_g2;
  logic wr_g3;
  logic wr_ctrl;
  logic [7:0] g1_w;
  logic [7:0] g2_w;
  logic [7:0] g3_w;
  logic pin2_hit;
  logic pin3_hit;
  logic [11:0] flag_v;
  logic [11:0] en_v;

  always_comb begin
    wr_g1 = 1'b0;
    wr_g2 = 1'b0;
    wr_g3 = 1'b0;
    wr_ctrl = 1'b0;
    if (reg_wr && reg_addr == `PIRQ_ADDR_GRP1) begin
      wr_g1 = 1'b1;
    end else if (reg_wr && reg_addr == `PIRQ_ADDR_GRP2) begin
      wr_g2 = 1'b1;
    end else if (reg_wr && reg_addr == `PIRQ_ADDR_GRP3) begin
      wr_g3 = 1'b1;
    end else if (reg_wr && reg_addr == `PIRQ_ADDR_CTRL) begin
      wr_ctrl = 1'b1;
    end
  end

  assign pin2_hit = edge_hit(st_r.ext_pin2_edge_select, st_r.pin2_prev, ext_pin2);
  assign pin3_hit = edge_hit(st_r.ext_pin3_edge_select, st_r.pin3_prev, ext_pin3);

  always_comb begin
    st_nxt = st_r;
    g1_w = wr_g1 ? reg_wdata : st_r.grp1;
    g2_w = wr_g2 ? reg_wdata : st_r.grp2;
    g3_w = wr_g3 ? reg_wdata : st_r.grp3;
    // Hardware set wins over a software clear in the same cycle
    g1_w[`PIRQ_G1_CONV_F] = g1_w[`PIRQ_G1_CONV_F] | src_event.converter;
    g1_w[`PIRQ_G1_MF1_F] = g1_w[`PIRQ_G1_MF1_F] | src_event.multifunc[1];
    g1_w[`PIRQ_G1_MF0_F] = g1_w[`PIRQ_G1_MF0_F] | src_event.multifunc[0];
    g1_w[`PIRQ_G1_CMP1_F] = g1_w[`PIRQ_G1_CMP1_F] | src_event.comparator1;
    g2_w[`PIRQ_G2_MF3_F] = g2_w[`PIRQ_G2_MF3_F] | src_event.multifunc[3];
    g2_w[`PIRQ_G2_TB1_F] = g2_w[`PIRQ_G2_TB1_F] | src_event.timebase1;
    g2_w[`PIRQ_G2_TB0_F] = g2_w[`PIRQ_G2_TB0_F] | src_event.timebase0;
    g2_w[`PIRQ_G2_MF2_F] = g2_w[`PIRQ_G2_MF2_F] | src_event.multifunc[2];
    g3_w[`PIRQ_G3_MF5_F] = g3_w[`PIRQ_G3_MF5_F] | src_event.multifunc[5];
    g3_w[`PIRQ_G3_MF4_F] = g3_w[`PIRQ_G3_MF4_F] | src_event.multifunc[4];
    g3_w[`PIRQ_G3_PIN3_F] = g3_w[`PIRQ_G3_PIN3_F] | pin3_hit;
    g3_w[`PIRQ_G3_PIN2_F] = g3_w[`PIRQ_G3_PIN2_F] | pin2_hit;
    st_nxt.grp1 = g1_w;
    st_nxt.grp2 = g2_w;
    st_nxt.grp3 = g3_w;
    if (wr_ctrl) begin
      st_nxt.global_irq_enable = reg_wdata[`PIRQ_CTRL_GIE];
      st_nxt.ext_pin2_edge_select = reg_wdata[`PIRQ_CTRL_P2S_LO +: 2];
      st_nxt.ext_pin3_edge_select = reg_wdata[`PIRQ_CTRL_P3S_LO +: 2];
    end
    st_nxt.pin2_prev = ext_pin2;
    st_nxt.pin3_prev = ext_pin3;
    // Order: converter, cmp1, tb0, tb1, pin2, pin3, mf0..mf5
    flag_v = {st_r.grp3[`PIRQ_G3_MF5_F], st_r.grp3[`PIRQ_G3_MF4_F], st_r.grp2[`PIRQ_G2_MF3_F],
              st_r.grp2[`PIRQ_G2_MF2_F], st_r.grp1[`PIRQ_G1_MF1_F], st_r.grp1[`PIRQ_G1_MF0_F],
              st_r.grp3[`PIRQ_G3_PIN3_F], st_r.grp3[`PIRQ_G3_PIN2_F], st_r.grp2[`PIRQ_G2_TB1_F],
              st_r.grp2[`PIRQ_G2_TB0_F], st_r.grp1[`PIRQ_G1_CMP1_F], st_r.grp1[`PIRQ_G1_CONV_F]};
    en_v = {st_r.grp3[`PIRQ_G3_MF5_E], st_r.grp3[`PIRQ_G3_MF4_E],
            st_r.grp2[`PIRQ_G2_MF3_E], st_r.grp2[`PIRQ_G2_MF2_E],
            st_r.grp1[`PIRQ_G1_MF1_E], st_r.grp1[`PIRQ_G1_MF0_E],
            st_r.grp3[`PIRQ_G3_PIN3_E], st_r.grp3[`PIRQ_G3_PIN2_E],
            st_r.grp2[`PIRQ_G2_TB1_E], st_r.grp2[`PIRQ_G2_TB0_E],
            st_r.grp1[`PIRQ_G1_CMP1_E], st_r.grp1[`PIRQ_G1_CONV_E]};
    st_nxt.irq_req = flag_v & en_v & {12{st_r.global_irq_enable}};
    st_nxt.rdata = `PIRQ_RST_BYTE;
    if (reg_rd && reg_addr == `PIRQ_ADDR_GRP1) begin
      st_nxt.rdata = st_r.grp1;
    end else if (reg_rd && reg_addr == `PIRQ_ADDR_GRP2) begin
      st_nxt.rdata = st_r.grp2;
    end else if (reg_rd && reg_addr == `PIRQ_ADDR_GRP3) begin
      st_nxt.rdata = st_r.grp3;
    end else if (reg_rd && reg_addr == `PIRQ_ADDR_CTRL) begin
      st_nxt.rdata[`PIRQ_CTRL_GIE] = st_r.global_irq_enable;
      st_nxt.rdata[`PIRQ_CTRL_P2S_LO +: 2] = st_r.ext_pin2_edge_select;
      st_nxt.rdata[`PIRQ_CTRL_P3S_LO +: 2] = st_r.ext_pin3_edge_select;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r.grp1 <= `PIRQ_RST_BYTE;
      st_r.grp2 <= `PIRQ_RST_BYTE;
      st_r.grp3 <= `PIRQ_RST_BYTE;
      st_r.global_irq_enable <= `PIRQ_RST_BIT;
      st_r.ext_pin2_edge_select <= `PIRQ_RST_EDGE;
      st_r.ext_pin3_edge_select <= `PIRQ_RST_EDGE;
      st_r.pin2_prev <= ext_pin2;
      st_r.pin3_prev <= ext_pin3;
      st_r.irq_req <= '0;
      st_r.rdata <= `PIRQ_RST_BYTE;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign irq_req = st_r.irq_req;

  a_conv_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && src_event.converter |=> st_r.grp1[`PIRQ_G1_CONV_F])
    else $error("converter flag not set");
  a_mf1_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && src_event.multifunc[1] |=> st_r.grp1[`PIRQ_G1_MF1_F])
    else $error("mf1 flag not set");
  a_tb1_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && src_event.timebase1 |=> st_r.grp2[`PIRQ_G2_TB1_F])
    else $error("tb1 flag not set");
  a_pin3_rise_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && st_r.ext_pin3_edge_select == `PIRQ_EDGE_RISE && ext_pin3 && !st_r.pin3_prev
    |=> st_r.grp3[`PIRQ_G3_PIN3_F])
    else $error("pin3 rising edge missed");
  a_pin2_off_quiet: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !wr_g3 && st_r.ext_pin2_edge_select == `PIRQ_EDGE_OFF && !st_r.grp3[`PIRQ_G3_PIN2_F]
    |=> !st_r.grp3[`PIRQ_G3_PIN2_F])
    else $error("pin2 flag set while disabled");
  a_gie_gates_req: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.global_irq_enable |=> irq_req == '0)
    else $error("request without global enable");
  a_mf0_req_path: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && st_r.global_irq_enable && st_r.grp1[`PIRQ_G1_MF0_E] && st_r.grp1[`PIRQ_G1_MF0_F]
    |=> irq_req[6])
    else $error("mf0 request not forwarded");
  a_tb0_en_block: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.grp2[`PIRQ_G2_TB0_E] |=> !irq_req[2])
    else $error("tb0 forwarded while disabled");
  a_read_group2: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && reg_rd && reg_addr == `PIRQ_ADDR_GRP2 |=> reg_rdata == $past(st_r.grp2))
    else $error("group 2 readback wrong");
  a_mf0_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && src_event.multifunc[0]
    |=> st_r.grp1[`PIRQ_G1_MF0_F])
    else $error("mf0 flag not set");
  a_cmp1_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && src_event.comparator1
    |=> st_r.grp1[`PIRQ_G1_CMP1_F])
    else $error("cmp1 flag not set");
  a_mf3_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && src_event.multifunc[3]
    |=> st_r.grp2[`PIRQ_G2_MF3_F])
    else $error("mf3 flag not set");
  a_tb0_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && src_event.timebase0
    |=> st_r.grp2[`PIRQ_G2_TB0_F])
    else $error("tb0 flag not set");
  a_mf2_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && src_event.multifunc[2]
    |=> st_r.grp2[`PIRQ_G2_MF2_F])
    else $error("mf2 flag not set");
  a_mf5_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && src_event.multifunc[5]
    |=> st_r.grp3[`PIRQ_G3_MF5_F])
    else $error("mf5 flag not set");
  a_mf4_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && src_event.multifunc[4]
    |=> st_r.grp3[`PIRQ_G3_MF4_F])
    else $error("mf4 flag not set");
  a_pin3_fall_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && st_r.ext_pin3_edge_select == `PIRQ_EDGE_FALL && !ext_pin3 && st_r.pin3_prev
    |=> st_r.grp3[`PIRQ_G3_PIN3_F])
    else $error("pin3 falling edge missed");
  a_pin2_rise_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && st_r.ext_pin2_edge_select == `PIRQ_EDGE_RISE && ext_pin2 && !st_r.pin2_prev
    |=> st_r.grp3[`PIRQ_G3_PIN2_F])
    else $error("pin2 rising edge missed");
  a_pin2_both_set: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && st_r.ext_pin2_edge_select == `PIRQ_EDGE_BOTH && ext_pin2 != st_r.pin2_prev
    |=> st_r.grp3[`PIRQ_G3_PIN2_F])
    else $error("pin2 edge missed in both mode");
  a_pin3_off_quiet: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !wr_g3 && st_r.ext_pin3_edge_select == `PIRQ_EDGE_OFF && !st_r.grp3[`PIRQ_G3_PIN3_F]
    |=> !st_r.grp3[`PIRQ_G3_PIN3_F])
    else $error("pin3 flag set while disabled");
  a_conv_flag_hold: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !wr_g1 && st_r.grp1[`PIRQ_G1_CONV_F]
    |=> st_r.grp1[`PIRQ_G1_CONV_F])
    else $error("converter flag lost");
  a_tb1_flag_clear: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && wr_g2 && !reg_wdata[`PIRQ_G2_TB1_F] && !src_event.timebase1
    |=> !st_r.grp2[`PIRQ_G2_TB1_F])
    else $error("tb1 flag not cleared");
  a_set_wins_clear: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && wr_g2 && !reg_wdata[`PIRQ_G2_TB0_F] && src_event.timebase0
    |=> st_r.grp2[`PIRQ_G2_TB0_F])
    else $error("clear beat a tb0 event");
  a_mf0_en_write: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && wr_g1 && reg_wdata[`PIRQ_G1_MF0_E]
    |=> st_r.grp1[`PIRQ_G1_MF0_E])
    else $error("mf0 enable not written");
  a_mf3_en_clear: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && wr_g2 && !reg_wdata[`PIRQ_G2_MF3_E]
    |=> !st_r.grp2[`PIRQ_G2_MF3_E])
    else $error("mf3 enable not cleared");
  a_pin3_en_write: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && wr_g3 && reg_wdata[`PIRQ_G3_PIN3_E]
    |=> st_r.grp3[`PIRQ_G3_PIN3_E])
    else $error("pin3 enable not written");
  a_g2_en_hold: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !wr_g2
    |=> $stable(st_r.grp2[`PIRQ_G2_MF3_E:`PIRQ_G2_MF2_E]))
    else $error("group 2 enables moved without a write");
  a_conv_en_block: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.grp1[`PIRQ_G1_CONV_E]
    |=> !irq_req[0])
    else $error("converter forwarded while disabled");
  a_cmp1_en_block: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.grp1[`PIRQ_G1_CMP1_E]
    |=> !irq_req[1])
    else $error("cmp1 forwarded while disabled");
  a_tb1_en_block: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.grp2[`PIRQ_G2_TB1_E]
    |=> !irq_req[3])
    else $error("tb1 forwarded while disabled");
  a_pin2_en_block: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.grp3[`PIRQ_G3_PIN2_E]
    |=> !irq_req[4])
    else $error("pin2 forwarded while disabled");
  a_pin3_en_block: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.grp3[`PIRQ_G3_PIN3_E]
    |=> !irq_req[5])
    else $error("pin3 forwarded while disabled");
  a_mf0_en_block: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.grp1[`PIRQ_G1_MF0_E]
    |=> !irq_req[6])
    else $error("mf0 forwarded while disabled");
  a_mf1_en_block: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.grp1[`PIRQ_G1_MF1_E]
    |=> !irq_req[7])
    else $error("mf1 forwarded while disabled");
  a_mf2_en_block: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.grp2[`PIRQ_G2_MF2_E]
    |=> !irq_req[8])
    else $error("mf2 forwarded while disabled");
  a_mf3_en_block: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.grp2[`PIRQ_G2_MF3_E]
    |=> !irq_req[9])
    else $error("mf3 forwarded while disabled");
  a_mf4_en_block: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.grp3[`PIRQ_G3_MF4_E]
    |=> !irq_req[10])
    else $error("mf4 forwarded while disabled");
  a_mf5_en_block: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.grp3[`PIRQ_G3_MF5_E]
    |=> !irq_req[11])
    else $error("mf5 forwarded while disabled");
  a_conv_req_path: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && st_r.global_irq_enable && st_r.grp1[`PIRQ_G1_CONV_E] && st_r.grp1[`PIRQ_G1_CONV_F]
    |=> irq_req[0])
    else $error("converter request not forwarded");
  a_pin3_req_path: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && st_r.global_irq_enable && st_r.grp3[`PIRQ_G3_PIN3_E] && st_r.grp3[`PIRQ_G3_PIN3_F]
    |=> irq_req[5])
    else $error("pin3 request not forwarded");
  a_mf4_flag_block: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !st_r.grp3[`PIRQ_G3_MF4_F]
    |=> !irq_req[10])
    else $error("mf4 forwarded without its flag");
  a_read_group1: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && reg_rd && reg_addr == `PIRQ_ADDR_GRP1
    |=> reg_rdata == $past(st_r.grp1))
    else $error("group 1 readback wrong");
  a_read_group3: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && reg_rd && reg_addr == `PIRQ_ADDR_GRP3
    |=> reg_rdata == $past(st_r.grp3))
    else $error("group 3 readback wrong");
  a_read_ctrl_gie: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && reg_rd && reg_addr == `PIRQ_ADDR_CTRL
    |=> reg_rdata[`PIRQ_CTRL_GIE] == $past(st_r.global_irq_enable))
    else $error("global enable readback wrong");
  a_read_idle_zero: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en && !reg_rd
    |=> reg_rdata == '0)
    else $error("read data outside its cycle");
  a_freeze_hold: assert property (@(posedge clk_sys) disable iff (srst)
    !clk_en
    |=> $stable(st_r))
    else $error("state moved while frozen");
  a_reset_clear: assert property (@(posedge clk_sys)
    srst
    |=> !st_r.global_irq_enable && irq_req == '0 && reg_rdata == '0)
    else $error("state not cleared by reset");

endmodule : pirq_top

//--- pirq_src_model.sv
/*
  Model of the interrupt sources: one-cycle event pulses and pin levels.
  Assumes the bench raises its requests just after a rising edge of clk_sys.
*/
`timescale 1ns/1ps
module pirq_src_model (
  input wire logic clk_sys,
  input wire logic fire,
  input wire logic [3:0] fire_sel,
  input wire logic pin2_lvl,
  input wire logic pin3_lvl,
  output pirq_pkg::pirq_src_type src_event,
  output logic ext_pin2,
  output logic ext_pin3
);
  // Outputs settle at the first edge, well inside the reset hold
  // A source pulses for exactly one cycle; pins move only after an edge
  always @(posedge clk_sys) begin
    src_event <= fire ? pirq_pkg::pirq_src_type'(10'h001 << fire_sel) : '0;
    ext_pin2 <= pin2_lvl;
    ext_pin3 <= pin3_lvl;
  end
endmodule : pirq_src_model

//--- pirq_top_test.sv
/*
  Self-checking bench for the primary interrupt flag and enable registers.
  Assumes the source model drives the event and pin inputs.
*/
`timescale 1ns/1ps
module pirq_top_test;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  pirq_pkg::pirq_src_type src_event;
  logic ext_pin2;
  logic ext_pin3;
  logic [11:0] irq_req;
  logic fire = 1'b0;
  logic [3:0] fire_sel = 4'h0;
  logic pin2_lvl = 1'b0;
  logic pin3_lvl = 1'b0;
  logic [7:0] rd_val;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // Per source: event bit, register, flag bit, enable bit, request bit
  localparam int SBIT[10] = '{9, 8, 7, 6, 0, 1, 2, 3, 4, 5};
  localparam int SREG[10] = '{1, 1, 2, 2, 1, 1, 2, 2, 3, 3};
  localparam int SFLG[10] = '{7, 4, 5, 6, 5, 6, 4, 7, 6, 7};
  localparam int SENA[10] = '{3, 0, 1, 2, 1, 2, 0, 3, 2, 3};
  localparam int SIRQ[10] = '{0, 1, 2, 3, 6, 7, 8, 9, 10, 11};

  pirq_top u_pirq_top (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_event(src_event), .ext_pin2(ext_pin2), .ext_pin3(ext_pin3), .irq_req(irq_req));
  pirq_src_model u_pirq_src_model (.clk_sys(clk_sys), .fire(fire), .fire_sel(fire_sel),
    .pin2_lvl(pin2_lvl), .pin3_lvl(pin3_lvl), .src_event(src_event), .ext_pin2(ext_pin2),
    .ext_pin3(ext_pin3));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  task automatic pulse(input int b);
    @(posedge clk_sys);
    fire <= 1'b1;
    fire_sel <= 4'(b);
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : pulse

  task automatic end_sim;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(2'(a));
      chk("reset value", {4'h0, rd_val}, 12'h000);
    end
    wr(2'h0, 8'hff);
    rd(2'h0);
    chk("ctrl readback", {4'h0, rd_val}, 12'h03d);
    for (int a = 1; a < 4; a++) begin
      wr(2'(a), 8'hff);
      rd(2'(a));
      chk("group readback", {4'h0, rd_val}, 12'h0ff);
      wr(2'(a), 8'h00);
    end
    for (int k = 0; k < 10; k++) begin
      wr(2'h0, 8'h01);
      wr(2'(SREG[k]), 8'h01 << SENA[k]);
      pulse(SBIT[k]);
      chk("request out", irq_req, 12'h001 << SIRQ[k]);
      rd(2'(SREG[k]));
      chk("flag and enable", {4'h0, rd_val}, (12'h001 << SFLG[k]) | (12'h001 << SENA[k]));
      wr(2'(SREG[k]), 8'h01 << SENA[k]);
      repeat (2) @(posedge clk_sys);
      #1 chk("request cleared", irq_req, 12'h000);
    end
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h08);
    pulse(9);
    chk("global off", irq_req, 12'h000);
    rd(2'h1);
    chk("flag with global off", {4'h0, rd_val}, 12'h088);
    wr(2'h1, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(2'h0, {2'b00, 2'(c), 2'(c), 2'b01});
      wr(2'h3, 8'h03);
      @(posedge clk_sys);
      pin2_lvl <= 1'b1;
      pin3_lvl <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 chk("pin rise", irq_req, (c % 2 == 1) ? 12'h030 : 12'h000);
      rd(2'h3);
      chk("pin flags", {4'h0, rd_val}, (c % 2 == 1) ? 12'h033 : 12'h003);
      wr(2'h3, 8'h03);
      @(posedge clk_sys);
      pin2_lvl <= 1'b0;
      pin3_lvl <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 chk("pin fall", irq_req, (c >= 2) ? 12'h030 : 12'h000);
      wr(2'h3, 8'h00);
    end
    // Event and a clearing write meet at one edge: the event wins
    @(posedge clk_sys);
    fire <= 1'b1;
    fire_sel <= 4'h7;
    @(posedge clk_sys);
    fire <= 1'b0;
    reg_addr <= 2'h2;
    reg_wdata <= 8'h00;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    rd(2'h2);
    chk("set beats clear", {4'h0, rd_val}, 12'h020);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(2'h1, 8'hff);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(2'h1);
    chk("frozen write", {4'h0, rd_val}, 12'h000);
    end_sim();
  end
endmodule : pirq_top_test
